// >>> bwa_pkg.sv
// package of constants, field layouts and helpers for the bank window address expander
package bwa_pkg;

  // ----------------------------------------------------------------
  // window size and base registers: two size bits and four base bits per window, plus decode mode
  // ----------------------------------------------------------------
  localparam logic [1:0] WIN_OFF = 2'h0;
  localparam logic [1:0] WIN_8K = 2'h1;
  localparam logic [1:0] WIN_16K = 2'h2;
  localparam logic [1:0] WIN_32K = 2'h3;
  localparam int SIZE_W1_LSB = 0;
  localparam int SIZE_W2_LSB = 2;
  localparam int SIZE_EXT_BIT = 4;
  localparam int BASE_W1_LSB = 0;
  localparam int BASE_W2_LSB = 4;

  // ----------------------------------------------------------------
  // general select control layout
  // ----------------------------------------------------------------
  localparam int GS_RANGE_LSB = 0;
  localparam int GS_COMB_LSB = 4;
  localparam int GS_POL_BIT = 6;
  localparam logic [3:0] GS_RANGE_OFF = 4'h0;
  localparam logic [3:0] GS_RANGE_MAX = 4'h9;
  localparam logic [3:0] GS_FOLLOW_W1 = 4'hA;
  localparam logic [3:0] GS_FOLLOW_W2 = 4'hB;
  localparam logic [1:0] GS_COMB_NONE = 2'h0;
  localparam logic [1:0] GS_COMB_OR = 2'h1;
  localparam logic [1:0] GS_COMB_AND = 2'h2;

  // ----------------------------------------------------------------
  // program and peripheral select control layout
  // ----------------------------------------------------------------
  localparam int PS_EN_BIT = 0;
  localparam int PS_SIZE_LSB = 1;
  localparam int PS_POL_BIT = 3;
  localparam int IO_EN_BIT = 4;
  localparam int IO_POL_BIT = 5;
  localparam int IO_BASE_LSB = 6;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [18:0] EXT_ADDR_RST = 19'h00000;
  localparam logic [5:0] PIN_RST = 6'h00;

  // compare mask over extended bits 18..11: code n keeps bits 18..(10+n)
  function automatic logic [7:0] sel_mask(input logic [3:0] code);
    sel_mask = 8'hFF << (code - 4'h1);
  endfunction : sel_mask

  // low extended lines 15..13 inside a window: bank bits or offset bits by size
  function automatic logic [2:0] ext_low(input logic [1:0] size, input logic [2:0] bank,
                                         input logic [2:0] offs);
    unique case (size)
      WIN_8K: ext_low = bank;
      WIN_16K: ext_low = {bank[2:1], offs[0]};
      default: ext_low = {bank[2], offs[1:0]};
    endcase
  endfunction : ext_low

endpackage : bwa_pkg

// >>> bwa_window.sv
// one window decoder: alignment check, hit and offset within the window
`timescale 1ns/1ns
`default_nettype none
module bwa_window
  import bwa_pkg::*;
(
  // cpu side
  input wire logic [15:0] addr_in,
  // configuration
  input wire logic [1:0] size_in,
  input wire logic [3:0] base_in,
  // decode result
  output logic hit_out,
  output logic [2:0] offs_out
);

  logic [15:0] offset;
  logic aligned;

  // offset bits, not cpu bits, feed the low lines: a 32 KB window at 4000
  // then sees line 14 inverted, which keeps its banks contiguous
  assign offset = addr_in - {base_in, 12'h000};
  assign offs_out = offset[15:13];

  always_comb begin
    unique case (size_in)
      WIN_8K: aligned = (base_in[0] == 1'b0);
      WIN_16K: aligned = (base_in[1:0] == 2'h0);
      WIN_32K: aligned = (base_in[1:0] == 2'h0) && (base_in[3:2] != 2'h3);
      default: aligned = 1'b0;
    endcase
  end

  // a misaligned start leaves the window closed rather than half mapped
  always_comb begin
    unique case (size_in)
      WIN_8K: hit_out = aligned && (offset[15:13] == 3'h0);
      WIN_16K: hit_out = aligned && (offset[15:14] == 2'h0);
      WIN_32K: hit_out = aligned && (offset[15] == 1'b0);
      default: hit_out = 1'b0;
    endcase
  end

endmodule : bwa_window
`default_nettype wire

// >>> bwa_gen_select.sv
// one general purpose select: raw match before polarity and combination
`timescale 1ns/1ns
`default_nettype none
module bwa_gen_select
  import bwa_pkg::*;
(
  // address sources
  input wire logic [15:0] cpu_addr_in,
  input wire logic [18:0] ext_addr_in,
  input wire logic ext_mode_in,
  input wire logic win1_hit_in,
  input wire logic win2_hit_in,
  // configuration
  input wire logic [3:0] range_in,
  input wire logic [7:0] start_in,
  // result
  output logic match_out
);

  logic [18:0] sel_addr;
  logic [7:0] mask;

  assign sel_addr = ext_mode_in ? ext_addr_in : {3'h0, cpu_addr_in};
  assign mask = sel_mask(range_in);

  always_comb begin
    if (range_in == GS_FOLLOW_W1) begin
      match_out = win1_hit_in;
    end else if (range_in == GS_FOLLOW_W2) begin
      match_out = win2_hit_in;
    end else if (range_in == GS_RANGE_OFF || range_in > GS_RANGE_MAX) begin
      match_out = 1'b0;
    end else begin
      match_out = ((sel_addr[18:11] ^ start_in) & mask) == 8'h00;
    end
  end

endmodule : bwa_gen_select
`default_nettype wire

// >>> bwa_expander.sv
// bank window address expander: extended address lines, port mux and chip selects
`timescale 1ns/1ns
`default_nettype none
module bwa_expander
  import bwa_pkg::*;
(
  // clock and reset
  input wire logic mclk_in,
  input wire logic nrst_in,
  // cpu bus
  input wire logic [15:0] cpu_addr_in,
  // window configuration
  input wire logic [4:0] window_size_reg_in,
  input wire logic [7:0] window_base_reg_in,
  input wire logic [5:0] window1_bank_reg_in,
  input wire logic [5:0] window2_bank_reg_in,
  // chip select configuration
  input wire logic [6:0] gen_select1_control_in,
  input wire logic [7:0] gen_select1_start_in,
  input wire logic [6:0] gen_select2_control_in,
  input wire logic [7:0] gen_select2_start_in,
  input wire logic [10:0] prog_io_select_control_in,
  // shared port
  input wire logic [5:0] port_addr_enable_reg_in,
  input wire logic [5:0] port_data_in,
  input wire logic [5:0] port_dir_in,
  input wire logic [5:0] port_pin_in,
  // extended address and pins
  output logic [18:0] ext_addr_out,
  output logic [5:0] ext_pin_out,
  output logic [5:0] ext_pin_oe_out,
  output logic [5:0] port_read_out,
  output logic [1:0] win_hit_out,
  // chip selects
  output logic gen_sel1_out,
  output logic gen_sel2_out,
  output logic prog_sel_out,
  output logic io_sel_out
);

  // ----------------------------------------------------------------
  // window decode
  // ----------------------------------------------------------------
  logic [1:0] size1;
  logic [1:0] size2;
  logic w1_hit;
  logic w2_raw;
  logic w2_hit;
  logic [2:0] offs1;
  logic [2:0] offs2;

  assign size1 = window_size_reg_in[SIZE_W1_LSB +: 2];
  assign size2 = window_size_reg_in[SIZE_W2_LSB +: 2];

  bwa_window u_win1 (
    .addr_in(cpu_addr_in),
    .size_in(size1),
    .base_in(window_base_reg_in[BASE_W1_LSB +: 4]),
    .hit_out(w1_hit),
    .offs_out(offs1)
  );

  bwa_window u_win2 (
    .addr_in(cpu_addr_in),
    .size_in(size2),
    .base_in(window_base_reg_in[BASE_W2_LSB +: 4]),
    .hit_out(w2_raw),
    .offs_out(offs2)
  );

  assign w2_hit = w2_raw && !w1_hit;

  // ----------------------------------------------------------------
  // extended address formation
  // ----------------------------------------------------------------
  logic [18:0] ext_addr_c;

  always_comb begin
    if (w1_hit) begin
      ext_addr_c = {window1_bank_reg_in[5:3],
                    ext_low(size1, window1_bank_reg_in[2:0], offs1),
                    cpu_addr_in[12:0]};
    end else if (w2_hit) begin
      ext_addr_c = {window2_bank_reg_in[5:3],
                    ext_low(size2, window2_bank_reg_in[2:0], offs2),
                    cpu_addr_in[12:0]};
    end else begin
      // outside both windows the upper lines rest low and the low ones pass through
      ext_addr_c = {3'h0, cpu_addr_in};
    end
  end

  // ----------------------------------------------------------------
  // general purpose selects
  // ----------------------------------------------------------------
  logic gs1_match;
  logic gs2_match;
  logic gs1_act;
  logic gs2_act;
  logic ext_mode;

  assign ext_mode = window_size_reg_in[SIZE_EXT_BIT];

  bwa_gen_select u_gs1 (
    .cpu_addr_in(cpu_addr_in),
    .ext_addr_in(ext_addr_c),
    .ext_mode_in(ext_mode),
    .win1_hit_in(w1_hit),
    .win2_hit_in(w2_raw),
    .range_in(gen_select1_control_in[GS_RANGE_LSB +: 4]),
    .start_in(gen_select1_start_in),
    .match_out(gs1_match)
  );

  bwa_gen_select u_gs2 (
    .cpu_addr_in(cpu_addr_in),
    .ext_addr_in(ext_addr_c),
    .ext_mode_in(ext_mode),
    .win1_hit_in(w1_hit),
    .win2_hit_in(w2_raw),
    .range_in(gen_select2_control_in[GS_RANGE_LSB +: 4]),
    .start_in(gen_select2_start_in),
    .match_out(gs2_match)
  );

  // combination looks at the other select's raw match, so no loop forms
  always_comb begin
    unique case (gen_select1_control_in[GS_COMB_LSB +: 2])
      GS_COMB_OR: gs1_act = gs1_match || gs2_match;
      GS_COMB_AND: gs1_act = gs1_match && gs2_match;
      default: gs1_act = gs1_match;
    endcase
    unique case (gen_select2_control_in[GS_COMB_LSB +: 2])
      GS_COMB_OR: gs2_act = gs2_match || gs1_match;
      GS_COMB_AND: gs2_act = gs2_match && gs1_match;
      default: gs2_act = gs2_match;
    endcase
  end

  // ----------------------------------------------------------------
  // program and peripheral selects
  // ----------------------------------------------------------------
  logic [2:0] prog_mask;
  logic prog_act;
  logic io_act;

  // program region sits at the top of the map, 8 KB times a power of two
  assign prog_mask = 3'h7 << prog_io_select_control_in[PS_SIZE_LSB +: 2];
  assign prog_act = prog_io_select_control_in[PS_EN_BIT]
                    && (&(cpu_addr_in[15:13] | ~prog_mask));
  assign io_act = prog_io_select_control_in[IO_EN_BIT]
                  && (cpu_addr_in[15:11] == prog_io_select_control_in[IO_BASE_LSB +: 5]);

  // ----------------------------------------------------------------
  // port pin input synchroniser
  // ----------------------------------------------------------------
  logic [5:0] pin_s1;
  logic [5:0] pin_s2;
  logic [5:0] pin_s3;

  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      pin_s1 <= PIN_RST;
      pin_s2 <= PIN_RST;
      pin_s3 <= PIN_RST;
    end else begin
      pin_s1 <= port_pin_in;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end

  // ----------------------------------------------------------------
  // next output values
  // ----------------------------------------------------------------
  logic [18:0] next_ext_addr;
  logic [5:0] next_pin;
  logic [5:0] next_pin_oe;
  logic [5:0] next_port_read;
  logic [1:0] next_win_hit;
  logic next_gs1;
  logic next_gs2;
  logic next_prog;
  logic next_io;

  always_comb begin
    next_ext_addr = ext_addr_c;
    next_win_hit = {w2_hit, w1_hit};
    next_gs1 = gs1_act ^ gen_select1_control_in[GS_POL_BIT];
    next_gs2 = gs2_act ^ gen_select2_control_in[GS_POL_BIT];
    next_prog = prog_act ^ prog_io_select_control_in[PS_POL_BIT];
    next_io = io_act ^ prog_io_select_control_in[IO_POL_BIT];
    next_port_read = port_read_out;
    for (int i = 0; i < 6; i++) begin
      if (port_addr_enable_reg_in[i]) begin
        next_pin[i] = ext_addr_c[13 + i];
        next_pin_oe[i] = 1'b1;
      end else begin
        next_pin[i] = port_data_in[i];
        next_pin_oe[i] = port_dir_in[i];
      end
      // a pin change is taken only once two late stages agree
      if (pin_s2[i] == pin_s3[i]) begin
        next_port_read[i] = pin_s3[i];
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      ext_addr_out <= EXT_ADDR_RST;
      ext_pin_out <= PIN_RST;
      ext_pin_oe_out <= PIN_RST;
      port_read_out <= PIN_RST;
      win_hit_out <= 2'h0;
      gen_sel1_out <= 1'b0;
      gen_sel2_out <= 1'b0;
      prog_sel_out <= 1'b0;
      io_sel_out <= 1'b0;
    end else begin
      ext_addr_out <= next_ext_addr;
      ext_pin_out <= next_pin;
      ext_pin_oe_out <= next_pin_oe;
      port_read_out <= next_port_read;
      win_hit_out <= next_win_hit;
      gen_sel1_out <= next_gs1;
      gen_sel2_out <= next_gs2;
      prog_sel_out <= next_prog;
      io_sel_out <= next_io;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!nrst_in);

  chk_upper_outside: assert property ($past(nrst_in) && !$past(w1_hit || w2_raw)
    |-> ext_addr_out[18:16] == 3'h0)
    else $error("upper extended lines active outside any window");

  chk_low_passthru: assert property ($past(nrst_in) && !$past(w1_hit || w2_raw)
    |-> ext_addr_out[15:0] == $past(cpu_addr_in))
    else $error("cpu address not passed through outside windows");

  chk_win1_bank: assert property ($past(nrst_in) && $past(w1_hit)
    |-> ext_addr_out[18:16] == $past(window1_bank_reg_in[5:3]))
    else $error("window one bank not driven");

  chk_first_wins: assert property ($past(nrst_in) && $past(w1_hit && w2_raw)
    |-> win_hit_out == 2'b01)
    else $error("second window drove lines during overlap");

  chk_win2_bank: assert property ($past(nrst_in) && $past(w2_hit)
    |-> ext_addr_out[18:16] == $past(window2_bank_reg_in[5:3]) && win_hit_out[1])
    else $error("window two bank not driven");

  chk_size8_low: assert property ($past(nrst_in) && $past(w1_hit && size1 == WIN_8K)
    |-> ext_addr_out[15:13] == $past(window1_bank_reg_in[2:0]))
    else $error("8 KB window low lines not from bank");

  chk_size16_a13: assert property ($past(nrst_in) && $past(w1_hit && size1 == WIN_16K)
    |-> ext_addr_out[13] == $past(cpu_addr_in[13])
        && ext_addr_out[15:14] == $past(window1_bank_reg_in[2:1]))
    else $error("16 KB window line mix wrong");

  chk_pin_gpio: assert property ($past(nrst_in) && !$past(port_addr_enable_reg_in[0])
    |-> ext_pin_oe_out[0] == $past(port_dir_in[0]) && ext_pin_out[0] == $past(port_data_in[0]))
    else $error("disabled address line did not leave port function");

  chk_pin_addr: assert property ($past(nrst_in) && $past(port_addr_enable_reg_in[1])
    |-> ext_pin_oe_out[1] && ext_pin_out[1] == ext_addr_out[14])
    else $error("enabled pin not carrying line 14");

  chk_follow_win: assert property ($past(nrst_in) && $past(gen_select1_control_in == 7'h0A)
    |-> gen_sel1_out == $past(w1_hit))
    else $error("select does not follow window one");

  chk_prog_top: assert property ($past(nrst_in) && $past(prog_io_select_control_in[3:0] == 4'h1)
    |-> prog_sel_out == ($past(cpu_addr_in[15:13]) == 3'h7))
    else $error("program select wrong over top 8 KB");

  chk_size32_low: assert property ($past(nrst_in) && $past(w2_hit && size2 == WIN_32K)
    |-> ext_addr_out[15] == $past(window2_bank_reg_in[2])
        && ext_addr_out[14:13] == $past(offs2[1:0]))
    else $error("32 KB window line mix wrong");

  chk_misalign_shut: assert property ($past(nrst_in)
    && $past(size1 == WIN_8K && window_base_reg_in[BASE_W1_LSB]) |-> !win_hit_out[0])
    else $error("misaligned window one opened");

  chk_io_block: assert property ($past(nrst_in)
    && $past(prog_io_select_control_in[IO_EN_BIT] && !prog_io_select_control_in[IO_POL_BIT])
    |-> io_sel_out == ($past(cpu_addr_in[15:11]) == $past(prog_io_select_control_in[10:6])))
    else $error("peripheral select wrong over its block");

  chk_sel1_polarity: assert property ($past(nrst_in) && $past(gen_select1_control_in[GS_POL_BIT]
    && gen_select1_control_in[GS_COMB_LSB +: 2] == GS_COMB_NONE)
    |-> gen_sel1_out == !$past(gs1_match))
    else $error("active low select one not inverted");

  cov_win1_hit: cover property (win_hit_out == 2'b01);
  cov_win2_hit: cover property (win_hit_out == 2'b10);
  cov_overlap: cover property (w1_hit && w2_raw);
  cov_gs_both: cover property (gen_sel1_out && gen_sel2_out);

endmodule : bwa_expander
`default_nettype wire

// >>> bwa_far_side.sv
// far side model: shared port pads with pull-ups and an external port driver
`timescale 1ns/1ns
`default_nettype none
module bwa_far_side
  import bwa_pkg::*;
(
  // pins from the expander
  input wire logic [5:0] pin_out_in,
  input wire logic [5:0] pin_oe_in,
  // external device on the shared port
  input wire logic [5:0] drv_en_in,
  input wire logic [5:0] drv_val_in,
  // resolved pad levels
  output logic [5:0] pad_out
);
  // ----------------------------------------------------------------
  // pad resolution
  // ----------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      if (pin_oe_in[i]) begin
        pad_out[i] = pin_out_in[i];
      end else if (drv_en_in[i]) begin
        pad_out[i] = drv_val_in[i];
      end else begin
        // undriven pads float to the pull-up, never to a stale value
        pad_out[i] = 1'b1;
      end
    end
  end
endmodule : bwa_far_side
`default_nettype wire

// >>> bank_window_address_expander_bench.sv
// self-checking bench for the bank window address expander
`timescale 1ns/1ns
`default_nettype none
module bank_window_address_expander_bench
  import bwa_pkg::*;
;
  // starting low before time zero keeps a false falling edge out of the reset count
  logic mclk_in = 1'b0;
  logic nrst_in;
  logic [15:0] cpu_addr;
  logic [4:0] wsize;
  logic [7:0] wbase, gs1, gs2;
  logic [5:0] bank1, bank2, pae, pdata, pdir, far_en, far_val, pad, pin_q, oe_q, rd_q;
  logic [6:0] gc1, gc2;
  logic [10:0] pio;
  logic [18:0] ext_addr;
  logic [1:0] hit_q;
  logic sel1_q, sel2_q, prog_q, io_q;
  int miscompares = 0;
  int check_count = 0;
  int cycles = 0;

  bwa_expander dut (.mclk_in(mclk_in), .nrst_in(nrst_in), .cpu_addr_in(cpu_addr),
    .window_size_reg_in(wsize), .window_base_reg_in(wbase), .window1_bank_reg_in(bank1),
    .window2_bank_reg_in(bank2), .gen_select1_control_in(gc1), .gen_select1_start_in(gs1),
    .gen_select2_control_in(gc2), .gen_select2_start_in(gs2),
    .prog_io_select_control_in(pio), .port_addr_enable_reg_in(pae), .port_data_in(pdata),
    .port_dir_in(pdir), .port_pin_in(pad), .ext_addr_out(ext_addr), .ext_pin_out(pin_q),
    .ext_pin_oe_out(oe_q), .port_read_out(rd_q), .win_hit_out(hit_q), .gen_sel1_out(sel1_q),
    .gen_sel2_out(sel2_q), .prog_sel_out(prog_q), .io_sel_out(io_q));

  bwa_far_side far (.pin_out_in(pin_q), .pin_oe_in(oe_q), .drv_en_in(far_en),
    .drv_val_in(far_val), .pad_out(pad));

  // ----------------------------------------------------------------
  // clock, timeout and verdict
  // ----------------------------------------------------------------
  initial begin
    forever #2 mclk_in = ~mclk_in;
  end

  task automatic report_and_stop();
    if (miscompares == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : report_and_stop

  always @(posedge mclk_in) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      report_and_stop();
    end
  end

  // ----------------------------------------------------------------
  // compares and reference model
  // ----------------------------------------------------------------
  task automatic cmp_addr(input logic [18:0] got, input logic [18:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_addr

  task automatic cmp_pin(input logic [5:0] got, input logic [5:0] exp);
    cmp_addr({13'h0000, got}, {13'h0000, exp});
  endtask : cmp_pin

  task automatic cmp_sel(input logic got, input logic exp);
    cmp_addr({18'h00000, got}, {18'h00000, exp});
  endtask : cmp_sel

  function automatic logic hit_of(input logic [15:0] a, input logic [1:0] sz,
                                  input logic [3:0] b);
    logic [4:0] span;
    logic ok;
    span = (sz == WIN_8K) ? 5'h02 : (sz == WIN_16K) ? 5'h04 : 5'h08;
    ok = (sz == WIN_8K) ? !b[0] : (b[1:0] == 2'h0) && !(sz == WIN_32K && b == 4'hC);
    hit_of = (sz != WIN_OFF) && ok && ({1'b0, a[15:12]} >= {1'b0, b})
             && ({1'b0, a[15:12]} < {1'b0, b} + span);
  endfunction : hit_of

  function automatic logic [18:0] exp_ext(input logic [15:0] a);
    logic [1:0] sz;
    logic [5:0] bk;
    logic [15:0] d;
    logic [2:0] lo;
    if (hit_of(a, wsize[1:0], wbase[3:0])) begin
      sz = wsize[1:0]; bk = bank1; d = a - {wbase[3:0], 12'h000};
    end else if (hit_of(a, wsize[3:2], wbase[7:4])) begin
      sz = wsize[3:2]; bk = bank2; d = a - {wbase[7:4], 12'h000};
    end else begin
      return {3'h0, a};
    end
    lo = (sz == WIN_8K) ? bk[2:0] : (sz == WIN_16K) ? {bk[2:1], d[13]} : {bk[2], d[14:13]};
    return {bk[5:3], lo, a[12:0]};
  endfunction : exp_ext

  function automatic logic gmatch(input logic [3:0] code, input logic [7:0] start,
                                  input logic [18:0] a19, input logic h1, input logic h2);
    if (code == GS_FOLLOW_W1) return h1;
    if (code == GS_FOLLOW_W2) return h2;
    if (code == GS_RANGE_OFF || code > GS_RANGE_MAX) return 1'b0;
    return ((a19[18:11] ^ start) & (8'hFF << (code - 4'h1))) == 8'h00;
  endfunction : gmatch

  function automatic logic comb(input logic [6:0] c, input logic own, input logic oth);
    logic m;
    m = (c[5:4] == GS_COMB_OR) ? (own | oth) : (c[5:4] == GS_COMB_AND) ? (own & oth) : own;
    return m ^ c[6];
  endfunction : comb

  // one cpu access: drive at the falling edge, check every output except port_read_out at the next falling edge
  task automatic step(input logic [15:0] a);
    logic [18:0] e, a19;
    logic h1, h2, m1, m2;
    logic [5:0] ep, eo;
    logic [3:0] top;
    cpu_addr = a;
    @(negedge mclk_in);
    h1 = hit_of(a, wsize[1:0], wbase[3:0]);
    h2 = hit_of(a, wsize[3:2], wbase[7:4]);
    e = exp_ext(a);
    a19 = wsize[SIZE_EXT_BIT] ? e : {3'h0, a};
    for (int i = 0; i < 6; i++) begin
      ep[i] = pae[i] ? e[13+i] : pdata[i];
      eo[i] = pae[i] | pdir[i];
    end
    m1 = gmatch(gc1[3:0], gs1, a19, h1, h2);
    m2 = gmatch(gc2[3:0], gs2, a19, h1, h2);
    top = 4'h8 - (4'h1 << pio[2:1]);
    cmp_addr(ext_addr, e);
    cmp_pin({4'h0, hit_q}, {4'h0, h2 & !h1, h1});
    cmp_pin(pin_q, ep);
    cmp_pin(oe_q, eo);
    cmp_sel(sel1_q, comb(gc1, m1, m2));
    cmp_sel(sel2_q, comb(gc2, m2, m1));
    cmp_sel(prog_q, (pio[0] & ({1'b0, a[15:13]} >= top)) ^ pio[3]);
    cmp_sel(io_q, (pio[4] & (a[15:11] == pio[10:6])) ^ pio[5]);
  endtask : step

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    nrst_in = 1'b0; cpu_addr = 16'h0000; wsize = 5'h00; wbase = 8'h00; bank1 = 6'h00;
    bank2 = 6'h00; gc1 = 7'h00; gc2 = 7'h00; gs1 = 8'h00; gs2 = 8'h00; pio = 11'h000;
    pae = 6'h00; pdata = 6'h00; pdir = 6'h00; far_en = 6'h00; far_val = 6'h00;
    repeat (3) @(negedge mclk_in);
    cmp_addr(ext_addr, EXT_ADDR_RST);
    nrst_in = 1'b1;
    @(negedge mclk_in);
    pae = 6'h3F; wsize = 5'h01; wbase = 8'h04; bank1 = 6'h2A;
    step(16'h4000);
    step(16'h5FFF);
    step(16'h6000);
    step(16'h3FFF);
    bank1 = 6'h15;
    step(16'h4000);
    wsize = 5'h02; wbase = 8'h08; bank1 = 6'h3F;
    step(16'hA123);
    wbase = 8'h02;
    step(16'h2000);
    wsize = 5'h01; wbase = 8'h03;
    step(16'h3000);
    wsize = 5'h03;
    for (int b = 0; b < 16; b += 4) begin
      wbase = {4'h0, b[3:0]};
      step({b[3:0], 12'h000} + 16'h6ABC);
    end
    wsize = 5'h0D; wbase = 8'h44; bank1 = 6'h2A; bank2 = 6'h13;
    step(16'h4000);
    step(16'h6000);
    step(16'hC000);
    pae = 6'h05; pdata = 6'h2A; pdir = 6'h30;
    step(16'h6000);
    wsize = 5'h00; pae = 6'h03;
    step(16'hE000);
    wsize = 5'h01; wbase = 8'h04; gc1 = 7'h4A; gs2 = 8'h08;
    for (int n = 0; n < 8; n++) begin
      bank1 = {3'h5, n[2:0]};
      step(16'h4000);
    end
    for (int c = 0; c < 4; c++) begin
      gc2 = {1'b0, c[1:0], 4'h1};
      step(16'h4000);
      step(16'h4800);
    end
    wsize = 5'h00; gs1 = 8'h08;
    for (int n = 1; n < 12; n++) begin
      gc1 = {3'h0, n[3:0]};
      step(16'h4000);
      step(16'h4800);
      step(16'h0000);
    end
    wsize = 5'h11; wbase = 8'h04; bank1 = 6'h2A; gc1 = 7'h01; gs1 = 8'hA8;
    step(16'h4000);
    bank1 = 6'h2B;
    step(16'h4000);
    for (int n = 0; n < 4; n++) begin
      pio = {5'h03, n[0], 1'b1, n[1], n[1:0], 1'b1};
      step(16'hC000);
      step(16'h1800);
      step(16'hE000);
    end
    pae = 6'h00; pdir = 6'h00; far_en = 6'h3F; far_val = 6'h2A;
    repeat (5) @(negedge mclk_in);
    cmp_pin(rd_q, 6'h2A);
    far_en = 6'h00; pdir = 6'h3F; pdata = 6'h15;
    repeat (5) @(negedge mclk_in);
    cmp_pin(rd_q, 6'h15);
    report_and_stop();
  end
endmodule : bank_window_address_expander_bench
`default_nettype wire
